// ==== include/dwpr_pkg.sv ====
// Shared constants and types for the write, precharge and refresh model
`default_nettype none
package dwpr_pkg;
	localparam int DWPR_BA_W = 3;
	localparam int DWPR_NBANK = 8;
	localparam int DWPR_ADDR_W = 16;
	localparam int DWPR_COL_W = 10;
	localparam int DWPR_DQ_W = 8;
	localparam int DWPR_A10 = 10;
	localparam int DWPR_A12 = 12;
	localparam int DWPR_MEM_W = 6;
	localparam int DWPR_MEM_DEPTH = 64;
	localparam int DWPR_CLK_NS = 10;
	localparam int DWPR_TRP_NS = 15;
	localparam int DWPR_TRP_CYC = (DWPR_TRP_NS + DWPR_CLK_NS - 1) / DWPR_CLK_NS;
	localparam int DWPR_TRFC_NS = 160;
	localparam int DWPR_TRFC_CYC =
		(DWPR_TRFC_NS + DWPR_CLK_NS - 1) / DWPR_CLK_NS;
	localparam int DWPR_TREFI_NS = 7800;
	localparam int DWPR_TREFI_CYC = DWPR_TREFI_NS / DWPR_CLK_NS;
	localparam int DWPR_TREFI_HOT_NS = 3900;
	localparam int DWPR_TREFI_HOT_CYC = DWPR_TREFI_HOT_NS / DWPR_CLK_NS;
	localparam int DWPR_VREF_WAIT_CYC = 512;
	localparam int DWPR_MAX_POSTED = 8;
	localparam int DWPR_BEATS_CHOP = 4;
	localparam int DWPR_BEATS_FULL = 8;
	localparam int DWPR_CNT_W = 10;
	localparam logic [DWPR_CNT_W-1:0] DWPR_TRP_Q =
		DWPR_CNT_W'(DWPR_TRP_CYC);
	localparam logic [DWPR_CNT_W-1:0] DWPR_TRFC_Q =
		DWPR_CNT_W'(DWPR_TRFC_CYC);
	localparam logic [DWPR_CNT_W-1:0] DWPR_VREF_Q =
		DWPR_CNT_W'(DWPR_VREF_WAIT_CYC);
	localparam logic [3:0] DWPR_CHOP_Q = 4'(DWPR_BEATS_CHOP);
	localparam logic [3:0] DWPR_FULL_Q = 4'(DWPR_BEATS_FULL);
	// Command code {row, col, we} strobes, active low
	localparam logic [2:0] DWPR_CMD_WRITE = 3'h4;
	localparam logic [2:0] DWPR_CMD_PRE = 3'h2;
	localparam logic [2:0] DWPR_CMD_REF = 3'h1;
	localparam logic [2:0] DWPR_CMD_ACT = 3'h3;
	localparam logic [2:0] DWPR_CMD_NOP = 3'h7;
	typedef enum logic [1:0] {
		DWPR_BK_IDLE = 2'h0,
		DWPR_BK_ACTIVE = 2'h1,
		DWPR_BK_PRECH = 2'h3
	} dwpr_bank_e;
	typedef enum logic [1:0] {
		DWPR_DV_NORMAL = 2'h0,
		DWPR_DV_REFRESH = 2'h1,
		DWPR_DV_SELF = 2'h3
	} dwpr_dev_e;
endpackage : dwpr_pkg
`default_nettype wire

// ==== include/dwpr_if.sv ====
// Command bus between controller and memory device
`default_nettype none
interface dwpr_if;
	import dwpr_pkg::*;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [DWPR_BA_W-1:0] ba;
	logic [DWPR_ADDR_W-1:0] addr;
	logic [DWPR_DQ_W-1:0] dq;
	logic dm;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dm);
	modport dram (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dm);
endinterface : dwpr_if
`default_nettype wire

// ==== verilog/dwpr_dram.sv ====
// Memory device end: bank states, burst write, precharge, refresh
`default_nettype none
module dwpr_dram
	import dwpr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Command bus
	dwpr_if.dram bus,
	// Mode and status
	input wire logic otf_en,
	input wire logic mode_full,
	output logic self_refresh,
	output logic refreshing,
	output logic [DWPR_NBANK-1:0] bank_open,
	output logic [DWPR_ADDR_W-1:0] refresh_row,
	// Array read port
	input wire logic [DWPR_MEM_W-1:0] rd_addr,
	output logic [DWPR_DQ_W-1:0] rd_data,
	output logic error
);
	typedef struct packed {
		logic [DWPR_NBANK-1:0][1:0] bk;
		logic [DWPR_NBANK-1:0][DWPR_CNT_W-1:0] pcnt;
		dwpr_dev_e dev;
		logic [DWPR_CNT_W-1:0] rcnt;
		logic cke_prev;
		logic wr_act;
		logic [3:0] beats;
		logic [3:0] beat;
		logic [DWPR_BA_W-1:0] wbank;
		logic [DWPR_MEM_W-1:0] waddr;
		logic wap;
		logic [DWPR_ADDR_W-1:0] rrow;
		logic [DWPR_DQ_W-1:0] rd;
		logic err;
	} dwpr_dram_s;
	dwpr_dram_s st_q, st_d;
	logic [DWPR_DQ_W-1:0] mem_q [DWPR_MEM_DEPTH];
	logic sel, wr_cmd, pre_cmd, ref_cmd, act_cmd, mem_we;
	logic [2:0] code;
	logic [DWPR_MEM_W-1:0] mem_a;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always_comb begin
		code = {bus.ras_n, bus.cas_n, bus.we_n};
		sel = !bus.cs_n && bus.cke && st_q.cke_prev;
		wr_cmd = sel && code == DWPR_CMD_WRITE;
		pre_cmd = sel && code == DWPR_CMD_PRE;
		act_cmd = sel && code == DWPR_CMD_ACT;
		ref_cmd = !bus.cs_n && st_q.cke_prev && code == DWPR_CMD_REF;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		mem_we = 1'b0;
		mem_a = st_q.waddr + DWPR_MEM_W'(st_q.beat);
		st_d.cke_prev = bus.cke;
		st_d.rd = mem_q[rd_addr];
		for (int b = 0; b < DWPR_NBANK; b++) begin
			if (st_q.bk[b] == DWPR_BK_PRECH) begin
				if (st_q.pcnt[b] <= DWPR_CNT_W'(1)) begin
					st_d.bk[b] = DWPR_BK_IDLE;
				end else begin
					st_d.pcnt[b] = st_q.pcnt[b] - DWPR_CNT_W'(1);
				end
			end
		end
		// Burst data, other banks may run meanwhile
		if (st_q.wr_act) begin
			mem_we = !bus.dm;
			st_d.beat = st_q.beat + 4'h1;
			if (st_q.beat + 4'h1 == st_q.beats) begin
				st_d.wr_act = 1'b0;
				if (st_q.wap) begin
					st_d.bk[st_q.wbank] = DWPR_BK_PRECH;
					st_d.pcnt[st_q.wbank] = DWPR_TRP_Q;
				end
			end
		end
		case (st_q.dev)
			DWPR_DV_NORMAL: begin
				if (wr_cmd) begin
					if (st_q.bk[bus.ba] != DWPR_BK_ACTIVE || st_q.wr_act) begin
						st_d.err = 1'b1;
					end else begin
						st_d.wr_act = 1'b1;
						st_d.beat = 4'h0;
						st_d.wbank = bus.ba;
						st_d.waddr = {bus.ba, bus.addr[2:0]};
						st_d.wap = bus.addr[DWPR_A10];
						st_d.beats = (otf_en ? bus.addr[DWPR_A12] : mode_full)
							? DWPR_FULL_Q : DWPR_CHOP_Q;
					end
				end
				if (act_cmd) begin
					if (st_q.bk[bus.ba] != DWPR_BK_IDLE) begin
						st_d.err = 1'b1;
					end else begin
						st_d.bk[bus.ba] = DWPR_BK_ACTIVE;
					end
				end
				if (pre_cmd) begin
					for (int b = 0; b < DWPR_NBANK; b++) begin
						if (bus.addr[DWPR_A10] || bus.ba == DWPR_BA_W'(b)) begin
							if (st_q.bk[b] == DWPR_BK_ACTIVE) begin
								st_d.bk[b] = DWPR_BK_PRECH;
								st_d.pcnt[b] = DWPR_TRP_Q;
							end else if (st_q.bk[b] == DWPR_BK_PRECH) begin
								st_d.pcnt[b] = DWPR_TRP_Q;
							end
						end
					end
				end
				if (ref_cmd) begin
					st_d.rrow = st_q.rrow + DWPR_ADDR_W'(1);
					st_d.rcnt = DWPR_TRFC_Q;
					if (!bus.cke) begin
						st_d.dev = DWPR_DV_SELF;
					end else begin
						st_d.dev = DWPR_DV_REFRESH;
					end
				end
			end
			DWPR_DV_REFRESH: begin
				if (sel && code != DWPR_CMD_NOP) begin
					st_d.err = 1'b1;
				end
				if (st_q.rcnt <= DWPR_CNT_W'(1)) begin
					st_d.dev = DWPR_DV_NORMAL;
				end else begin
					st_d.rcnt = st_q.rcnt - DWPR_CNT_W'(1);
				end
			end
			DWPR_DV_SELF: begin
				// Array held, no command taken until cke returns
				if (bus.cke) begin
					st_d.dev = DWPR_DV_NORMAL;
				end
			end
			default: st_d.dev = DWPR_DV_NORMAL;
		endcase
	end

	// ----------------------------------------
	// Registers and array
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem_q[mem_a] <= bus.dq;
		end
	end

	always_comb begin
		for (int b = 0; b < DWPR_NBANK; b++) begin
			bank_open[b] = st_q.bk[b] == DWPR_BK_ACTIVE;
		end
	end
	assign self_refresh = st_q.dev == DWPR_DV_SELF;
	assign refreshing = st_q.dev == DWPR_DV_REFRESH;
	assign refresh_row = st_q.rrow;
	assign rd_data = st_q.rd;
	assign error = st_q.err;
endmodule : dwpr_dram
`default_nettype wire

// ==== verilog/dwpr_ctrl.sv ====
// Controller end: issues commands and paces refresh
`default_nettype none
module dwpr_ctrl
	import dwpr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Command bus
	dwpr_if.ctrl bus,
	// User request
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [DWPR_BA_W-1:0] req_ba,
	input wire logic [DWPR_ADDR_W-1:0] req_addr,
	input wire logic req_flag,
	input wire logic [DWPR_DQ_W-1:0] req_data,
	input wire logic req_mask,
	input wire logic hot,
	input wire logic self_req,
	output logic req_ready,
	output logic [3:0] posted
);
	typedef struct packed {
		logic [DWPR_CNT_W-1:0] wait_c;
		logic [DWPR_CNT_W-1:0] vref_c;
		logic [12:0] refi_c;
		logic [3:0] posted;
		logic in_self;
		logic cke;
		logic [2:0] code;
		logic cs_n;
		logic [DWPR_BA_W-1:0] ba;
		logic [DWPR_ADDR_W-1:0] addr;
		logic [DWPR_DQ_W-1:0] dq;
		logic dm;
	} dwpr_ctrl_s;
	dwpr_ctrl_s st_q, st_d;
	logic [12:0] refi_lim;
	logic ref_due;

	// ----------------------------------------
	// Issue logic; ops 0 act, 1 write, 2 pre, 3 refresh
	// ----------------------------------------
	always_comb begin
		refi_lim = hot ? 13'(DWPR_TREFI_HOT_CYC) : 13'(DWPR_TREFI_CYC);
		ref_due = st_q.posted >= 4'(DWPR_MAX_POSTED);
		req_ready = st_q.wait_c == '0 && !st_q.in_self && !ref_due
			&& !(req_op == 2'h1 && st_q.vref_c != '0);
		st_d = st_q;
		st_d.cs_n = 1'b1;
		st_d.code = DWPR_CMD_NOP;
		st_d.dm = req_mask;
		st_d.dq = req_data;
		if (st_q.wait_c != '0) begin
			st_d.wait_c = st_q.wait_c - DWPR_CNT_W'(1);
		end
		if (st_q.vref_c != '0) begin
			st_d.vref_c = st_q.vref_c - DWPR_CNT_W'(1);
		end
		if (st_q.refi_c >= refi_lim - 13'h1) begin
			st_d.refi_c = '0;
			if (st_q.posted < 4'(DWPR_MAX_POSTED)) begin
				st_d.posted = st_q.posted + 4'h1;
			end
		end else begin
			st_d.refi_c = st_q.refi_c + 13'h1;
		end
		if (st_q.in_self) begin
			if (!self_req) begin
				st_d.cke = 1'b1;
				st_d.in_self = 1'b0;
				st_d.vref_c = DWPR_VREF_Q;
			end
		end else if (st_q.wait_c == '0 && (ref_due || self_req)) begin
			st_d.cs_n = 1'b0;
			st_d.code = DWPR_CMD_REF;
			st_d.cke = !self_req;
			st_d.in_self = self_req;
			st_d.wait_c = DWPR_TRFC_Q;
			if (st_d.posted != '0) begin
				st_d.posted = st_d.posted - 4'h1;
			end
		end else if (req_valid && req_ready) begin
			st_d.cs_n = 1'b0;
			st_d.ba = req_ba;
			st_d.addr = req_addr;
			case (req_op)
				2'h0: begin
					st_d.code = DWPR_CMD_ACT;
					st_d.wait_c = DWPR_TRP_Q;
				end
				2'h1: begin
					st_d.code = DWPR_CMD_WRITE;
					st_d.addr[DWPR_A10] = req_flag;
					st_d.wait_c = DWPR_CNT_W'(DWPR_BEATS_FULL);
				end
				2'h2: begin
					st_d.code = DWPR_CMD_PRE;
					st_d.wait_c = DWPR_TRP_Q;
				end
				default: begin
					st_d.code = DWPR_CMD_REF;
					st_d.wait_c = DWPR_TRFC_Q;
					if (st_d.posted != '0) begin
						st_d.posted = st_d.posted - 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= '0;
			st_q.cke <= 1'b1;
			st_q.cs_n <= 1'b1;
			st_q.code <= DWPR_CMD_NOP;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.cke = st_q.cke;
	assign bus.cs_n = st_q.cs_n;
	assign bus.ras_n = st_q.code[2];
	assign bus.cas_n = st_q.code[1];
	assign bus.we_n = st_q.code[0];
	assign bus.ba = st_q.ba;
	assign bus.addr = st_q.addr;
	assign bus.dq = st_q.dq;
	assign bus.dm = st_q.dm;
	assign posted = st_q.posted;
endmodule : dwpr_ctrl
`default_nettype wire

// ==== tb/dwpr_chk.sv ====
// Bus checker for the controller to memory command interface
`default_nettype none
module dwpr_chk
	import dwpr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Command bus
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [DWPR_BA_W-1:0] ba,
	input wire logic [DWPR_ADDR_W-1:0] addr,
	input wire logic [DWPR_DQ_W-1:0] dq,
	input wire logic dm
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [2:0] cmd;
	logic cke_q;
	int rfc_q;
	int gap_q;
	int vref_q;
	assign cmd = {ras_n, cas_n, we_n};
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cke_q <= 1'b1;
			rfc_q <= 0;
			gap_q <= 0;
			vref_q <= 0;
		end else begin
			cke_q <= cke;
			rfc_q <= (!cs_n && cmd == DWPR_CMD_REF) ? DWPR_TRFC_CYC - 1 :
				(rfc_q > 0 ? rfc_q - 1 : 0);
			gap_q <= ((!cs_n && cmd == DWPR_CMD_REF) || !cke) ? 0 : gap_q + 1;
			vref_q <= (cke && !cke_q) ? DWPR_VREF_WAIT_CYC - 1 :
				(vref_q > 0 ? vref_q - 1 : 0);
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_wr; !cs_n && cmd == DWPR_CMD_WRITE; endsequence
	sequence s_pre; !cs_n && cmd == DWPR_CMD_PRE; endsequence
	sequence s_act; !cs_n && cmd == DWPR_CMD_ACT; endsequence
	sequence s_ref; !cs_n && cmd == DWPR_CMD_REF; endsequence
	property p_wr_cke; s_wr |-> cke && cke_q; endproperty
	property p_cke_cmd; (s_pre or s_act) |-> cke && cke_q; endproperty
	property p_ref_quiet;
		(rfc_q != 0 && cke && !cs_n) |-> cmd == DWPR_CMD_NOP;
	endproperty
	property p_trp; s_pre |=> (cs_n || cmd != DWPR_CMD_ACT); endproperty
	property p_burst; s_wr |=> (cs_n || cmd != DWPR_CMD_WRITE) [*3]; endproperty
	property p_sr_entry; $fell(cke) |-> s_ref; endproperty
	property p_gap; gap_q <= 9 * DWPR_TREFI_CYC; endproperty
	property p_vref; s_wr |-> vref_q == 0; endproperty
	a_wr_cke: assert property (p_wr_cke) else $error("write without cke");
	a_cke_cmd: assert property (p_cke_cmd) else $error("cke low at cmd");
	a_ref_quiet: assert property (p_ref_quiet) else $error("cmd in trfc");
	a_trp: assert property (p_trp) else $error("act inside trp");
	a_burst: assert property (p_burst) else $error("burst cut short");
	a_sr_entry: assert property (p_sr_entry) else $error("bad sr entry");
	a_gap: assert property (p_gap) else $error("refresh gap too long");
	a_vref: assert property (p_vref) else $error("write too early");
endmodule : dwpr_chk
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench joining controller and memory ends
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	miscompares++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top
	import dwpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk_sys = 0, nrst = 0, req_valid = 0, req_flag = 0, req_mask = 0;
	logic otf_en = 1, mode_full = 0, hot = 0, self_req = 0;
	logic [1:0] req_op = 0;
	logic [DWPR_BA_W-1:0] req_ba = 0;
	logic [DWPR_ADDR_W-1:0] req_addr = 0, r0, refresh_row;
	logic [DWPR_DQ_W-1:0] req_data = 0, rd_data;
	logic [DWPR_MEM_W-1:0] rd_addr = 0;
	logic req_ready, self_refresh, refreshing, error;
	logic [3:0] posted;
	logic [DWPR_NBANK-1:0] bank_open;
	int miscompares = 0, tests_run = 0;
	dwpr_if bus ();
	dwpr_ctrl i_dwpr_ctrl (.clk_sys(clk_sys), .nrst(nrst), .bus(bus.ctrl),
		.req_valid(req_valid), .req_op(req_op), .req_ba(req_ba),
		.req_addr(req_addr), .req_flag(req_flag), .req_data(req_data),
		.req_mask(req_mask), .hot(hot), .self_req(self_req),
		.req_ready(req_ready), .posted(posted));
	dwpr_dram i_dwpr_dram (.clk_sys(clk_sys), .nrst(nrst), .bus(bus.dram),
		.otf_en(otf_en), .mode_full(mode_full), .self_refresh(self_refresh),
		.refreshing(refreshing), .bank_open(bank_open),
		.refresh_row(refresh_row), .rd_addr(rd_addr), .rd_data(rd_data),
		.error(error));
	dwpr_chk i_dwpr_chk (.clk_sys(clk_sys), .nrst(nrst), .cke(bus.cke),
		.cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
		.we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr), .dq(bus.dq),
		.dm(bus.dm));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic req(input logic [1:0] op, input logic [2:0] b,
		input logic [15:0] a, input logic f);
		int n;
		n = 0;
		tick(1);
		{req_op, req_ba, req_addr, req_flag, req_valid} = {op, b, a, f, 1'b1};
		#1;
		while (req_ready !== 1'b1 && n < 1000) begin
			tick(1);
			#1;
			n++;
		end
		if (n == 1000) miscompares++;
		tick(1);
		req_valid = 1'b0;
	endtask : req
	task automatic wr(input logic [2:0] b, input logic [15:0] a,
		input logic f, input logic [7:0] d0, input int nb, input int mb);
		req(2'h1, b, a, f);
		for (int k = 0; k < nb; k++) begin
			req_data = d0 + 8'(k);
			req_mask = (k == mb);
			tick(1);
		end
		req_mask = 1'b0;
		tick(4);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		rd_addr = a;
		tick(1);
		`CHK("rd_data", e, rd_data)
	endtask : rd
	task automatic end_sim;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		miscompares++;
		end_sim;
	end
	initial begin
		tick(10);
		nrst = 1'b1;
		tick(1);
		`CHK("bank_open", 8'h00, bank_open)
		`CHK("posted", 4'h0, posted)
		req(2'h0, 3'h1, 16'h0000, 1'b0);
		tick(3);
		`CHK("bank_open", 8'h02, bank_open)
		wr(3'h1, 16'h1000, 1'b0, 8'hA0, 8, 9);
		wr(3'h1, 16'h0000, 1'b0, 8'h50, 4, 1);
		for (int k = 0; k < 8; k++) begin
			rd(6'(8 + k), (k == 1 || k > 3) ? 8'(8'hA0 + k) : 8'(8'h50 + k));
		end
		`CHK("bank_open", 8'h02, bank_open)
		wr(3'h1, 16'h0004, 1'b1, 8'h30, 4, 9);
		tick(4);
		`CHK("bank_open", 8'h00, bank_open)
		rd(6'h0C, 8'h30);
		req(2'h0, 3'h2, 16'h0000, 1'b0);
		req(2'h0, 3'h3, 16'h0000, 1'b0);
		req(2'h2, 3'h2, 16'h0000, 1'b0);
		tick(3);
		`CHK("bank_open", 8'h08, bank_open)
		req(2'h2, 3'h5, 16'h0000, 1'b0);
		req(2'h2, 3'h0, 16'h0400, 1'b1);
		tick(3);
		`CHK("bank_open", 8'h00, bank_open)
		`CHK("error", 1'b0, error)
		r0 = refresh_row;
		req(2'h3, 3'h7, 16'hFFFF, 1'b0);
		tick(2);
		`CHK("refreshing", 1'b1, refreshing)
		tick(20);
		`CHK("refresh_row", 16'(r0 + 1), refresh_row)
		req(2'h3, 3'h0, 16'h0000, 1'b0);
		tick(20);
		`CHK("refresh_row", 16'(r0 + 2), refresh_row)
		self_req = 1'b1;
		for (int n = 0; n < 100 && self_refresh !== 1'b1; n++) tick(1);
		`CHK("self_refresh", 1'b1, self_refresh)
		tick(50);
		rd(6'h0C, 8'h30);
		self_req = 1'b0;
		for (int n = 0; n < 100 && self_refresh !== 1'b0; n++) tick(1);
		`CHK("self_refresh", 1'b0, self_refresh)
		req(2'h0, 3'h4, 16'h0000, 1'b0);
		wr(3'h4, 16'h0000, 1'b0, 8'h70, 4, 9);
		rd(6'h20, 8'h70);
		otf_en = 1'b0;
		mode_full = 1'b1;
		wr(3'h4, 16'h0000, 1'b0, 8'h80, 8, 9);
		rd(6'h27, 8'h87);
		tick(8000);
		`CHK("error", 1'b0, error)
		`CHK("refresh_row", 1'b1, refresh_row != 16'(r0 + 3))
		hot = 1'b1;
		r0 = refresh_row;
		tick(1500);
		`CHK("hot_refresh", 1'b1, 16'(refresh_row - r0) >= 16'h3)
		`CHK("error", 1'b0, error)
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
